// *** clfc_pkg.sv ***
// constants for the converter limit / frequency configuration bank
// assumes an 8-bit register port fed by the device's serial slave front end
package clfc_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_RSVD_A = 8'h15;
    localparam logic [7:0] ADDR_RSVD_B = 8'h16;
    localparam logic [7:0] ADDR_CURLIM = 8'h17;
    localparam logic [7:0] ADDR_RSVD_C = 8'h18;
    localparam logic [7:0] ADDR_RSVD_D = 8'h19;
    localparam logic [7:0] ADDR_UVLVL = 8'h1A;
    localparam logic [7:0] ADDR_RSVD_E = 8'h1B;
    localparam logic [7:0] ADDR_RSVD_F = 8'h1C;
    localparam logic [7:0] ADDR_FREQ = 8'h1D;
    // first and last address of the bank
    localparam logic [7:0] ADDR_FIRST = ADDR_RSVD_A;
    localparam logic [7:0] ADDR_LAST = ADDR_FREQ;
    // number of byte registers in the bank
    localparam int NUM_REGS = 9;
    // storage index of each functional register
    localparam logic [3:0] IDX_CURLIM = 4'h2;
    localparam logic [3:0] IDX_UVLVL = 4'h5;
    localparam logic [3:0] IDX_FREQ = 4'h8;
    // reset defaults, index 0 (0x15) in the low byte
    localparam logic [71:0] REG_DEFAULTS = {
        8'h83, 8'h40, 8'h40, 8'h00, 8'h00, 8'h64, 8'h64, 8'h80, 8'h80};
    // value read back from an unmapped address
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    // current limit register fields
    localparam int CC_OFF_BIT = 7;
    localparam int CC_MSB = 6;
    // undervoltage register fields
    localparam int UV_MSB = 6;
    // frequency / thermal register fields
    localparam int FREQ_MSB = 7;
    localparam int FREQ_LSB = 6;
    localparam int DIE_HEAT_THRESHOLD_MSB = 1;
    localparam int DIE_HEAT_THRESHOLD_LSB = 0;
    // scaling clamp limits in percent
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam logic [6:0] PCT_FLOOR = 7'h01;
    // undervoltage threshold base and step in millivolts
    localparam logic [15:0] UV_BASE_MV = 16'h1388;
    localparam logic [15:0] UV_STEP_MV = 16'h0064;
    // switching rate codes and their rates in kHz
    localparam logic [1:0] RATE_125K = 2'h0;
    localparam logic [1:0] RATE_250K = 2'h1;
    localparam logic [1:0] RATE_500K = 2'h2;
    localparam logic [10:0] KHZ_125 = 11'h07D;
    localparam logic [10:0] KHZ_250 = 11'h0FA;
    localparam logic [10:0] KHZ_500 = 11'h1F4;
    localparam logic [10:0] KHZ_1000 = 11'h3E8;
    // die heat threshold codes and their values in degrees C
    localparam logic [1:0] HEAT_OFF = 2'h0;
    localparam logic [1:0] HEAT_80C = 2'h1;
    localparam logic [1:0] HEAT_100C = 2'h2;
    localparam logic [6:0] DEG_0 = 7'h00;
    localparam logic [6:0] DEG_80 = 7'h50;
    localparam logic [6:0] DEG_100 = 7'h64;
    localparam logic [6:0] DEG_120 = 7'h78;
endpackage

// *** clfc_scale.sv ***
// current scaling clamp: maps the raw 7-bit code to an effective percent
// assumes a raw code straight from the current limit register
`timescale 1ns/1ps
`default_nettype none
module clfc_scale (
    input wire logic [6:0] raw_code,
    output logic [6:0] pct
);
    // clamp the code into the 1..100 percent window
    always_comb begin
        if (raw_code >= clfc_pkg::PCT_FULL) begin
            pct = clfc_pkg::PCT_FULL;
        end else if (raw_code < clfc_pkg::PCT_FLOOR) begin
            pct = clfc_pkg::PCT_FLOOR;
        end else begin
            pct = raw_code;
        end
    end
endmodule
`default_nettype wire

// *** clfc_decode.sv ***
// decodes undervoltage, switching rate and die heat fields to physical values
// assumes raw fields taken straight from the register storage
`timescale 1ns/1ps
`default_nettype none
module clfc_decode (
    input wire logic [6:0] uv_code,
    input wire logic [1:0] rate_code,
    input wire logic [1:0] heat_code,
    output logic [15:0] uv_mv,
    output logic [10:0] rate_khz,
    output logic heat_en,
    output logic [6:0] heat_deg
);
    always_comb begin
        uv_mv = clfc_pkg::UV_BASE_MV + 16'({9'h000, uv_code}) * clfc_pkg::UV_STEP_MV;
    end

    always_comb begin
        case (rate_code)
            clfc_pkg::RATE_125K: rate_khz = clfc_pkg::KHZ_125;
            clfc_pkg::RATE_250K: rate_khz = clfc_pkg::KHZ_250;
            clfc_pkg::RATE_500K: rate_khz = clfc_pkg::KHZ_500;
            default: rate_khz = clfc_pkg::KHZ_1000;
        endcase
    end

    always_comb begin
        heat_en = (heat_code != clfc_pkg::HEAT_OFF);
        case (heat_code)
            clfc_pkg::HEAT_OFF: heat_deg = clfc_pkg::DEG_0;
            clfc_pkg::HEAT_80C: heat_deg = clfc_pkg::DEG_80;
            clfc_pkg::HEAT_100C: heat_deg = clfc_pkg::DEG_100;
            default: heat_deg = clfc_pkg::DEG_120;
        endcase
    end
endmodule
`default_nettype wire

// *** clfc_regs.sv ***
// configuration bank at 0x15..0x1D: current limit, input undervoltage level,
// switching rate and die heat regulation threshold, plus reserved bytes
// assumes a byte-wide register port driven by the serial slave front end,
// synchronous to clk; the analog loops consume the registered outputs
//
// Operation
// - disable bit set turns limiting off
// - scale field is binary percent of ceiling
// - codes 100 and above clamp to 100%
// - codes zero and one both give 1%
// - undervoltage level: 5V plus 100mV steps
// - two-bit select picks 125k to 1MHz
// - two-bit field: off, 80, 100, 120C
`timescale 1ns/1ps
`default_nettype none
module clfc_regs (
    // core clock, rising edge
    input wire logic clk,
    // asynchronous reset, active low
    input wire logic arst_n,
    // byte address of the access
    input wire logic [7:0] reg_addr,
    // one-cycle write strobe
    input wire logic reg_wr,
    // byte to store on a write
    input wire logic [7:0] reg_wdata,
    // one-cycle read strobe
    input wire logic reg_rd,
    // read answer, held until the next read
    output logic [7:0] reg_rdata,
    // read answer valid, one cycle
    output logic reg_rvalid,
    // high turns constant-current limiting off
    output logic const_current_off,
    // effective scale, 1 to 100 percent of the ceiling
    output logic [6:0] current_scale_pct,
    // undervoltage threshold in millivolts
    output logic [15:0] input_undervoltage_level,
    // raw switching rate select code
    output logic [1:0] switching_rate_select,
    // switching rate in kHz
    output logic [10:0] switching_rate_khz,
    // high while die heat regulation is on
    output logic die_heat_regulate_en,
    // die heat threshold in degrees C, zero when off
    output logic [6:0] die_heat_threshold
);
    // register map, storage index counted from 0x15:
    //   0 at 0x15: reserved_field, default 0x80
    //   1 at 0x16: reserved_field, default 0x80
    //   2 at 0x17: output_current_limit, off bit 7, scale code 6..0
    //   3 at 0x18: reserved_field, default 0x64
    //   4 at 0x19: reserved_field, default 0x00
    //   5 at 0x1A: input_undervoltage_threshold, code 6..0
    //   6 at 0x1B: reserved_field, default 0x40
    //   7 at 0x1C: reserved_field, default 0x40
    //   8 at 0x1D: switching_freq_thermal_setting, rate 7..6, heat 1..0
    // timing: storage loads on the write edge and the decoded outputs
    // one edge later, so the analog side sees a write one edge after
    // it is taken; a read answers on the next edge with reg_rvalid
    // byte storage for every register of the bank
    logic [7:0] bank_r [0:clfc_pkg::NUM_REGS-1];
    // offset of the access address from the bank start
    logic [7:0] offset_w;
    // storage index of the addressed register
    logic [3:0] index_w;
    // address falls inside the bank
    logic hit_w;

    // address decode shared by reads and writes; an address below the
    // bank wraps to a large offset, so the index may alias a real byte
    // and every use of index_w is gated by hit_w as well
    always_comb begin
        offset_w = reg_addr - clfc_pkg::ADDR_FIRST;
        index_w = offset_w[3:0];
        hit_w = (reg_addr >= clfc_pkg::ADDR_FIRST) && (reg_addr <= clfc_pkg::ADDR_LAST);
    end

    // one storage byte per register, loaded from its own default at reset
    genvar gi;
    generate
        for (gi = 0; gi < clfc_pkg::NUM_REGS; gi++) begin : g_bank
            // next value of this byte
            logic [7:0] byte_nxt;

            always_comb begin
                if (reg_wr && hit_w && (index_w == 4'(gi))) begin
                    // addressed write; reserved bytes take writes too,
                    // the host is trusted to rewrite their defaults
                    byte_nxt = reg_wdata;
                end else begin
                    // hold
                    byte_nxt = bank_r[gi];
                end
            end

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    bank_r[gi] <= clfc_pkg::REG_DEFAULTS[gi*8 +: 8];
                end else begin
                    bank_r[gi] <= byte_nxt;
                end
            end
        end
    endgenerate

    // read path next values
    // answer byte for the coming edge
    logic [7:0] rdata_nxt;
    // answer strobe for the coming edge
    logic rvalid_nxt;
    // registered read path
    // answer byte, held between reads
    logic [7:0] rdata_r;
    // answer strobe, one cycle per read
    logic rvalid_r;

    // read returns stored byte, unmapped returns a fixed value; a read and
    // a write of one byte in one cycle return the old byte, since storage
    // only loads on that same edge
    always_comb begin
        rvalid_nxt = reg_rd;
        if (reg_rd && hit_w) begin
            rdata_nxt = bank_r[index_w];
        end else if (reg_rd) begin
            // outside the bank
            rdata_nxt = clfc_pkg::UNMAPPED_DATA;
        end else begin
            // hold last answer
            rdata_nxt = rdata_r;
        end
    end

    // read path registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            // empty answer byte after reset
            rdata_r <= 8'h00;
            // no answer pending after reset
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // raw fields pulled from storage
    // output current limit byte
    logic [7:0] curlim_w;
    // undervoltage threshold byte
    logic [7:0] uvlvl_w;
    // switching rate and heat byte
    logic [7:0] freq_w;
    // decoded values from the leaf modules
    // clamped scale percent
    logic [6:0] pct_w;
    // threshold in millivolts
    logic [15:0] uv_mv_w;
    // rate in kHz
    logic [10:0] khz_w;
    // heat regulation on
    logic heat_en_w;
    // heat threshold in degrees C
    logic [6:0] heat_deg_w;

    // pick the functional registers out of the bank
    always_comb begin
        curlim_w = bank_r[clfc_pkg::IDX_CURLIM];
        uvlvl_w = bank_r[clfc_pkg::IDX_UVLVL];
        freq_w = bank_r[clfc_pkg::IDX_FREQ];
    end

    // effective scaling percent
    clfc_scale u_scale (
        // scale code, off bit left out
        .raw_code(curlim_w[clfc_pkg::CC_MSB:0]),
        // clamped percent
        .pct(pct_w)
    );

    // physical values of the remaining fields
    clfc_decode u_decode (
        // threshold code, reserved top bit left out
        .uv_code(uvlvl_w[clfc_pkg::UV_MSB:0]),
        // rate select code
        .rate_code(freq_w[clfc_pkg::FREQ_MSB:clfc_pkg::FREQ_LSB]),
        // heat threshold code
        .heat_code(freq_w[clfc_pkg::DIE_HEAT_THRESHOLD_MSB:clfc_pkg::DIE_HEAT_THRESHOLD_LSB]),
        // threshold in millivolts
        .uv_mv(uv_mv_w),
        // rate in kHz
        .rate_khz(khz_w),
        // heat regulation on
        .heat_en(heat_en_w),
        // heat threshold in degrees C
        .heat_deg(heat_deg_w)
    );

    // next values of the control outputs
    // limiting off
    logic cc_off_nxt;
    // clamped percent
    logic [6:0] pct_nxt;
    // threshold in millivolts
    logic [15:0] uv_nxt;
    // raw rate code
    logic [1:0] rate_nxt;
    // rate in kHz
    logic [10:0] khz_nxt;
    // heat regulation on
    logic heat_en_nxt;
    // heat threshold in degrees C
    logic [6:0] heat_nxt;
    // registered control outputs
    // limiting off
    logic cc_off_r;
    // clamped percent
    logic [6:0] pct_r;
    // threshold in millivolts
    logic [15:0] uv_r;
    // raw rate code
    logic [1:0] rate_r;
    // rate in kHz
    logic [10:0] khz_r;
    // heat regulation on
    logic heat_en_r;
    // heat threshold in degrees C
    logic [6:0] heat_r;

    // control outputs follow the stored fields one cycle later;
    // registering keeps every port a flop output and hands the analog
    // side a level free of decode glitches
    always_comb begin
        cc_off_nxt = curlim_w[clfc_pkg::CC_OFF_BIT];
        pct_nxt = pct_w;
        uv_nxt = uv_mv_w;
        // rate code and value; a change is applied as written
        // the host keeps it to idle periods
        rate_nxt = freq_w[clfc_pkg::FREQ_MSB:clfc_pkg::FREQ_LSB];
        khz_nxt = khz_w;
        heat_en_nxt = heat_en_w;
        heat_nxt = heat_deg_w;
    end

    // control output registers, reset to the decoded defaults
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            // limiting active
            cc_off_r <= 1'b0;
            // default code clamps to full scale
            pct_r <= clfc_pkg::PCT_FULL;
            // code zero, base level
            uv_r <= clfc_pkg::UV_BASE_MV;
            // default rate code
            rate_r <= clfc_pkg::RATE_500K;
            // default rate value
            khz_r <= clfc_pkg::KHZ_500;
            // regulation on by default
            heat_en_r <= 1'b1;
            // highest threshold by default
            heat_r <= clfc_pkg::DEG_120;
        end else begin
            cc_off_r <= cc_off_nxt;
            pct_r <= pct_nxt;
            uv_r <= uv_nxt;
            rate_r <= rate_nxt;
            khz_r <= khz_nxt;
            heat_en_r <= heat_en_nxt;
            heat_r <= heat_nxt;
        end
    end

    // drive the ports straight from flops
    // read answer byte
    assign reg_rdata = rdata_r;
    // read answer strobe
    assign reg_rvalid = rvalid_r;
    // limiting off
    assign const_current_off = cc_off_r;
    // clamped percent
    assign current_scale_pct = pct_r;
    // threshold in millivolts
    assign input_undervoltage_level = uv_r;
    // raw rate code
    assign switching_rate_select = rate_r;
    // rate in kHz
    assign switching_rate_khz = khz_r;
    // heat regulation on
    assign die_heat_regulate_en = heat_en_r;
    // heat threshold in degrees C
    assign die_heat_threshold = heat_r;
endmodule
`default_nettype wire

// *** clfc_regs_properties.sv ***
// checker for the limit / frequency configuration bank ports
// assumes one clk domain; bound onto every clfc_regs instance
`timescale 1ns/1ps
`default_nettype none
module clfc_regs_properties (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic reg_rvalid,
    input wire logic const_current_off,
    input wire logic [6:0] current_scale_pct,
    input wire logic [15:0] input_undervoltage_level,
    input wire logic [1:0] switching_rate_select,
    input wire logic [10:0] switching_rate_khz,
    input wire logic die_heat_regulate_en,
    input wire logic [6:0] die_heat_threshold
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // writes aimed at each functional register
    logic wr_cl, wr_uv, wr_fq;
    assign wr_cl = reg_wr && (reg_addr == clfc_pkg::ADDR_CURLIM);
    assign wr_uv = reg_wr && (reg_addr == clfc_pkg::ADDR_UVLVL);
    assign wr_fq = reg_wr && (reg_addr == clfc_pkg::ADDR_FREQ);
    a_rd_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("answer without read");
    a_cc_off_bit: assert property (wr_cl |-> ##2
        const_current_off == $past(reg_wdata[7], 2)) else $error("limit disable wrong");
    a_scale_mid: assert property (wr_cl && reg_wdata[6:0] inside {[7'h02:7'h63]}
        |-> ##2 current_scale_pct == $past(reg_wdata[6:0], 2)) else $error("scale wrong");
    a_scale_top: assert property (wr_cl && reg_wdata[6:0] >= 7'h64
        |-> ##2 current_scale_pct == 7'h64) else $error("scale not clamped");
    a_scale_floor: assert property (wr_cl && reg_wdata[6:0] <= 7'h01
        |-> ##2 current_scale_pct == 7'h01) else $error("scale floor wrong");
    a_uv_step: assert property (wr_uv |-> ##2 input_undervoltage_level ==
        16'h1388 + 16'h0064 * {9'h000, $past(reg_wdata[6:0], 2)})
        else $error("uv level wrong");
    a_rate_sel: assert property (wr_fq |-> ##2
        switching_rate_select == $past(reg_wdata[7:6], 2)) else $error("rate select wrong");
    a_rate_khz: assert property (switching_rate_khz ==
        ((switching_rate_select == 2'h0) ? 11'h07D :
        (switching_rate_select == 2'h1) ? 11'h0FA :
        (switching_rate_select == 2'h2) ? 11'h1F4 : 11'h3E8))
        else $error("rate khz wrong");
    a_heat_code: assert property (wr_fq |-> ##2
        die_heat_regulate_en == ($past(reg_wdata[1:0], 2) != 2'h0))
        else $error("heat enable wrong");
    a_heat_deg: assert property (wr_fq |-> ##2 die_heat_threshold ==
        (($past(reg_wdata[1:0], 2) == 2'h0) ? 7'h00 :
        ($past(reg_wdata[1:0], 2) == 2'h1) ? 7'h50 :
        ($past(reg_wdata[1:0], 2) == 2'h2) ? 7'h64 : 7'h78))
        else $error("heat threshold wrong");
endmodule
bind clfc_regs clfc_regs_properties clfc_regs_properties_i (.clk, .arst_n, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rvalid, .const_current_off, .current_scale_pct,
    .input_undervoltage_level, .switching_rate_select, .switching_rate_khz,
    .die_heat_regulate_en, .die_heat_threshold);
`default_nettype wire

// *** clfc_host.sv ***
// host model driving the bank's byte register port
// assumes inputs change 1 ns after a rising clk edge
`timescale 1ns/1ps
`default_nettype none
module clfc_host (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // one read, answer taken 1 ns after the edge that samples the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        d = reg_rdata;
        v = reg_rvalid;
    endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the configuration bank
// assumes clfc_host drives the register port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, arst_n, reg_wr, reg_rd, reg_rvalid, cc_off, heat_en, rv;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_d;
    logic [6:0] pct, deg;
    logic [15:0] uv;
    logic [1:0] sel;
    logic [10:0] khz;
    int n_fail = 0;
    int compares = 0;
    localparam logic [7:0] DFLT [9] = '{8'h80, 8'h80, 8'h64, 8'h64, 8'h00, 8'h00, 8'h40, 8'h40,
        8'h83};
    localparam logic [6:0] SC [6] = '{7'h00, 7'h01, 7'h02, 7'h63, 7'h64, 7'h7F};
    localparam logic [6:0] SX [6] = '{7'h01, 7'h01, 7'h02, 7'h63, 7'h64, 7'h64};
    localparam logic [10:0] KT [4] = '{11'h07D, 11'h0FA, 11'h1F4, 11'h3E8};
    localparam logic [6:0] DT [4] = '{7'h00, 7'h50, 7'h64, 7'h78};
    clfc_host clfc_host_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    clfc_regs clfc_regs_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .const_current_off(cc_off), .current_scale_pct(pct), .input_undervoltage_level(uv),
        .switching_rate_select(sel), .switching_rate_khz(khz), .die_heat_regulate_en(heat_en),
        .die_heat_threshold(deg));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // read one byte and judge answer
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        clfc_host_i.rd(a, rd_d, rv);
        chk(16'(rv), 16'h0001);
        chk(16'(rd_d), 16'(exp));
    endtask
    // decoded outputs land one edge after the write edge; wait two edges
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic t_reset();
        for (int i = 0; i < 9; i++) rd_chk(8'h15 + 8'(i), DFLT[i]);
        chk(16'(pct), 16'h0064);
        chk(uv, 16'h1388);
        chk(16'(sel), 16'h0002);
        chk(16'(khz), 16'h01F4);
        chk(16'(heat_en), 16'h0001);
        chk(16'(deg), 16'h0078);
        chk(16'(cc_off), 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_scale();
        for (int i = 0; i < 6; i++) begin
            clfc_host_i.wr(clfc_pkg::ADDR_CURLIM, {i[0], SC[i]});
            settle();
            chk(16'(pct), 16'(SX[i]));
            chk(16'(cc_off), 16'(i[0]));
            rd_chk(clfc_pkg::ADDR_CURLIM, {i[0], SC[i]});
        end
        $display("test scale done");
    endtask
    task automatic t_uv();
        logic [6:0] c;
        for (int i = 0; i < 4; i++) begin
            c = (i == 3) ? 7'h7F : (i == 2) ? 7'h40 : 7'(i);
            clfc_host_i.wr(clfc_pkg::ADDR_UVLVL, {1'b0, c});
            settle();
            chk(uv, 16'h1388 + 16'h0064 * 16'(c));
            rd_chk(clfc_pkg::ADDR_UVLVL, {1'b0, c});
        end
        $display("test uv done");
    endtask
    task automatic t_freq();
        for (int i = 0; i < 4; i++) begin
            clfc_host_i.wr(clfc_pkg::ADDR_FREQ, {2'(i), 4'h0, 2'(i)});
            settle();
            chk(16'(sel), 16'(i));
            chk(16'(khz), 16'(KT[i]));
            chk(16'(heat_en), 16'(i != 0));
            chk(16'(deg), 16'(DT[i]));
            rd_chk(clfc_pkg::ADDR_FREQ, {2'(i), 4'h0, 2'(i)});
        end
        $display("test freq done");
    endtask
    task automatic t_unmapped();
        clfc_host_i.wr(8'h14, 8'h5A);
        clfc_host_i.wr(8'h1E, 8'hA5);
        rd_chk(8'h14, 8'h00);
        rd_chk(8'h1E, 8'h00);
        rd_chk(clfc_pkg::ADDR_RSVD_A, 8'h80);
        rd_chk(clfc_pkg::ADDR_FREQ, 8'hC3);
        $display("test unmapped done");
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        #20000;
        n_fail++;
        finish_test();
    end
    // main sequence, with a second reset mid-run
    initial begin
        arst_n = 1'b0;
        repeat (8) @(posedge clk);
        #1 arst_n = 1'b1;
        t_reset();
        t_scale();
        t_uv();
        t_freq();
        t_unmapped();
        arst_n = 1'b0;
        repeat (8) @(posedge clk);
        #1 arst_n = 1'b1;
        t_reset();
        finish_test();
    end
endmodule
`default_nettype wire
